// ===== rtl/usbep_endpoint.sv
// single endpoint transaction logic with apb register port
// How it works
// - connect sense pin synchronised; pull-up output follows a config bit.
// - bulk max packet is 8, 16, 32 or 64 bytes by size field.
// - interrupt endpoints take packets up to 256 bytes.
// - setup, data in/out and status in/out tracked as control stage.
// - control transfer opens with setup, then data stages, then status.
// - force-stall bit makes in/out tokens answer with stall.
// - setup packets are acknowledged at once without software.
// - setup sets setup-received flag and lands in the fifo bank.
// - interrupt follows the flags, gated by the interrupt enable bit.
// - out packets are taken again only once the setup-received and data-received flags are clear.
// - host ack on data in sets transmit-complete, raising interrupt.
// - ping-pong on in data: cpu owns one bank, bus side the other; received packets always use bank 0.
// - acknowledged bank returns to the cpu for the next payload.
// - in token with no ready bank is answered with nak.
// - fifo bytes are moved as 8-bit values over apb.
// - register port and bus side share pclk in this build.
`timescale 1ns/1ps
`default_nettype none
module usbep_endpoint #(
  parameter int DEPTH = 256
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                ce,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output var  logic [31:0]         prdata,
  output var  logic                pready,
  output var  logic                pslverr,
  input  wire logic                host_connect_sense,
  output var  logic                dp_pullup_enable,
  output var  logic                ep_irq,
  input  wire usbep_pkg::usbep_tok_t sie_tok,
  input  wire usbep_pkg::usbep_rx_t  sie_rx,
  input  wire usbep_pkg::usbep_ack_t sie_ack,
  input  wire logic                sie_tx_ready,
  output var  usbep_pkg::usbep_tx_t  sie_tx,
  output var  usbep_pkg::usbep_hs_t  sie_hs
);
  localparam int IW = $clog2(DEPTH);
  localparam int CW = IW + 1;
  localparam int ILIM = (usbep_pkg::INTR_MAX < DEPTH) ? usbep_pkg::INTR_MAX
                                                      : DEPTH;

  // ==========================================================
  // state
  logic [7:0]  mem [2*DEPTH];
  logic [2:0]  sync_reg, sync_next;
  logic        conn_reg, conn_next, pup_reg, pup_next;
  logic        prdy_reg, prdy_next;
  logic [31:0] prd_reg, prd_next;
  logic [7:0]  cfg_reg, cfg_next;
  logic        txc_reg, txc_next, rxd_reg, rxd_next;
  logic        set_reg, set_next, sts_reg, sts_next;
  logic        fst_reg, fst_next;
  logic [1:0]  pkr_reg, pkr_next;
  logic        cb_reg, cb_next, sb_reg, sb_next;
  logic [CW-1:0] len_reg [2];
  logic [CW-1:0] len_next [2];
  logic [CW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [CW-1:0] rc_reg, rc_next, cnt_reg, cnt_next;
  logic [CW-1:0] ti_reg, ti_next;
  logic        dir_reg, dir_next, hasd_reg, hasd_next;
  logic        isset_reg, isset_next;
  usbep_pkg::usbep_state_t st_reg, st_next;
  usbep_pkg::usbep_stage_t stg_reg, stg_next;
  usbep_pkg::usbep_tx_t    tx_reg, tx_next;
  usbep_pkg::usbep_hs_t    hs_reg, hs_next;
  logic          mem_we, tx_load, acc, first, ctl, pp, mapped;
  logic [IW:0]   mem_wa;
  logic [7:0]    mem_wd;
  logic [CW-1:0] maxpkt;
  int            bsz;

  assign pready  = prdy_reg;
  assign prdata  = prd_reg;
  assign pslverr = prdy_reg & ~mapped;
  assign sie_tx  = tx_reg;
  assign sie_hs  = hs_reg;
  assign dp_pullup_enable = pup_reg;
  assign ctl = cfg_reg[usbep_pkg::CFG_TYP +: 2] == usbep_pkg::TYP_CTRL;
  assign pp  = cfg_reg[usbep_pkg::CFG_PP];
  assign mapped = paddr == usbep_pkg::OFF_CFG || paddr == usbep_pkg::OFF_CSR
               || paddr == usbep_pkg::OFF_FDR || paddr == usbep_pkg::OFF_STAT;
  assign ep_irq = cfg_reg[usbep_pkg::CFG_IEN]
                & (set_reg | txc_reg | rxd_reg | sts_reg);

  // ==========================================================
  // packet size limit per endpoint type
  always_comb begin
    // for bulk and interrupt, a bank smaller than the type's limit caps the packet instead
    bsz = usbep_pkg::BULK_MIN << cfg_reg[usbep_pkg::CFG_SZ +: 2];
    unique case (cfg_reg[usbep_pkg::CFG_TYP +: 2])
      usbep_pkg::TYP_CTRL: maxpkt = CW'(usbep_pkg::CTRL_SIZE);
      usbep_pkg::TYP_BULK: maxpkt = bsz < DEPTH ? CW'(bsz) : CW'(DEPTH);
      usbep_pkg::TYP_INTR: maxpkt = CW'(ILIM);
      default:             maxpkt = CW'(DEPTH);
    endcase
  end

  // ==========================================================
  // next state
  always_comb begin
    sync_next = {sync_reg[1:0], host_connect_sense};
    // first stage feeds only the second; decision on stages two and three
    conn_next = (sync_reg[1] == sync_reg[2]) ? sync_reg[2] : conn_reg;
    pup_next  = cfg_reg[usbep_pkg::CFG_PUP];
    cfg_next = cfg_reg;
    txc_next = txc_reg;
    rxd_next = rxd_reg;
    set_next = set_reg;
    sts_next = sts_reg;
    fst_next = fst_reg;
    pkr_next = pkr_reg;
    cb_next  = cb_reg;
    sb_next  = sb_reg;
    len_next = len_reg;
    wp_next  = wp_reg;
    rp_next  = rp_reg;
    rc_next  = rc_reg;
    cnt_next = cnt_reg;
    ti_next  = ti_reg;
    dir_next = dir_reg;
    hasd_next  = hasd_reg;
    isset_next = isset_reg;
    st_next  = st_reg;
    stg_next = stg_reg;
    tx_next  = tx_reg;
    hs_next  = '0;
    tx_load  = 1'b0;
    mem_we   = 1'b0;
    mem_wa   = '0;
    mem_wd   = '0;
    prd_next = prd_reg;

    // apb: one wait state, read data latched in the first access cycle
    first     = psel & penable & ~prdy_reg;
    acc       = psel & penable & prdy_reg;
    prdy_next = first;
    if (first) begin
      prd_next = '0;
      unique case (paddr)
        usbep_pkg::OFF_CFG: prd_next[7:0] = cfg_reg;
        usbep_pkg::OFF_CSR: begin
          prd_next[usbep_pkg::CSR_TXC] = txc_reg;
          prd_next[usbep_pkg::CSR_RXD] = rxd_reg;
          prd_next[usbep_pkg::CSR_SET] = set_reg;
          prd_next[usbep_pkg::CSR_STS] = sts_reg;
          prd_next[usbep_pkg::CSR_PKR] = |pkr_reg;
          prd_next[usbep_pkg::CSR_FST] = fst_reg;
          prd_next[usbep_pkg::CSR_CNT +: CW] = cnt_reg;
        end
        usbep_pkg::OFF_FDR:
          prd_next[7:0] = mem[{1'b0, rp_reg[IW-1:0]}];
        usbep_pkg::OFF_STAT: begin
          prd_next[usbep_pkg::STAT_CON] = conn_reg;
          prd_next[usbep_pkg::STAT_STG +: 3] = stg_reg;
          prd_next[usbep_pkg::STAT_CB] = cb_reg;
          prd_next[usbep_pkg::STAT_SB] = sb_reg;
        end
        default: prd_next = '0;
      endcase
    end
    if (acc && !pwrite && paddr == usbep_pkg::OFF_FDR && rp_reg < cnt_reg)
      rp_next = rp_reg + CW'(1);
    if (acc && pwrite) begin
      unique case (paddr)
        usbep_pkg::OFF_CFG: cfg_next = pwdata[7:0];
        usbep_pkg::OFF_CSR: begin
          // write one to clear; hardware sets below override
          if (pwdata[usbep_pkg::CSR_TXC]) txc_next = 1'b0;
          if (pwdata[usbep_pkg::CSR_RXD]) rxd_next = 1'b0;
          if (pwdata[usbep_pkg::CSR_SET]) set_next = 1'b0;
          if (pwdata[usbep_pkg::CSR_STS]) sts_next = 1'b0;
          fst_next = pwdata[usbep_pkg::CSR_FST];
          if (pwdata[usbep_pkg::CSR_PKR] && !pkr_reg[cb_reg]) begin
            pkr_next[cb_reg] = 1'b1;
            len_next[cb_reg] = wp_reg;
            wp_next = '0;
            if (pp)
              cb_next = ~cb_reg;
          end
        end
        usbep_pkg::OFF_FDR:
          if (wp_reg < CW'(DEPTH)) begin
            mem_we  = 1'b1;
            mem_wa  = {cb_reg, wp_reg[IW-1:0]};
            mem_wd  = pwdata[7:0];
            wp_next = wp_reg + CW'(1);
          end
        default: ;
      endcase
    end

    // bus side transactions
    unique case (st_reg)
      usbep_pkg::S_IDLE:
        if (sie_tok.valid) begin
          unique case (sie_tok.kind)
            usbep_pkg::TK_SETUP: begin
              // a setup always lands, cancelling any stall
              st_next = usbep_pkg::S_RX;
              rc_next = '0;
              isset_next = 1'b1;
              fst_next = 1'b0;
            end
            usbep_pkg::TK_OUT: begin
              hs_next.valid = 1'b1;
              if (fst_reg) begin
                hs_next.code = usbep_pkg::HS_STALL;
                sts_next = 1'b1;
              end else if (set_reg || rxd_reg) begin
                hs_next.code = usbep_pkg::HS_NAK;
              end else begin
                hs_next.valid = 1'b0;
                st_next = usbep_pkg::S_RX;
                rc_next = '0;
                isset_next = 1'b0;
                if (ctl && stg_reg != usbep_pkg::G_IDLE)
                  stg_next = ((stg_reg == usbep_pkg::G_SETUP && !dir_reg
                              && hasd_reg) || stg_reg == usbep_pkg::G_DOUT)
                             ? usbep_pkg::G_DOUT : usbep_pkg::G_SOUT;
              end
            end
            usbep_pkg::TK_IN: begin
              if (fst_reg) begin
                hs_next = '{valid: 1'b1, code: usbep_pkg::HS_STALL};
                sts_next = 1'b1;
              end else if (pkr_reg[sb_reg]) begin
                st_next = usbep_pkg::S_TX;
                ti_next = '0;
                tx_load = 1'b1;
                if (ctl && stg_reg != usbep_pkg::G_IDLE)
                  stg_next = ((stg_reg == usbep_pkg::G_SETUP && dir_reg
                              && hasd_reg) || stg_reg == usbep_pkg::G_DIN)
                             ? usbep_pkg::G_DIN : usbep_pkg::G_SIN;
              end else begin
                hs_next = '{valid: 1'b1, code: usbep_pkg::HS_NAK};
              end
            end
            default: ;
          endcase
        end
      usbep_pkg::S_RX:
        if (sie_rx.valid) begin
          if (!sie_rx.empty && rc_reg < maxpkt) begin
            mem_we  = 1'b1;
            mem_wa  = {1'b0, rc_reg[IW-1:0]};
            mem_wd  = sie_rx.data;
            rc_next = rc_reg + CW'(1);
            if (isset_reg && rc_reg == '0)
              dir_next = sie_rx.data[7];
            if (isset_reg && rc_reg == CW'(usbep_pkg::SETUP_LEN_LO))
              hasd_next = |sie_rx.data;
            if (isset_reg && rc_reg == CW'(usbep_pkg::SETUP_LEN_HI))
              hasd_next = hasd_reg | (|sie_rx.data);
          end
          if (sie_rx.last) begin
            st_next = usbep_pkg::S_IDLE;
            if (sie_rx.crc_ok) begin
              hs_next = '{valid: 1'b1, code: usbep_pkg::HS_ACK};
              cnt_next = rc_next;
              rp_next  = '0;
              if (isset_reg) begin
                set_next = 1'b1;
                stg_next = usbep_pkg::G_SETUP;
              end else begin
                rxd_next = 1'b1;
              end
            end
          end
        end
      usbep_pkg::S_TX:
        if (sie_tx_ready) begin
          if (tx_reg.last) begin
            st_next = usbep_pkg::S_WAIT;
            tx_next = '0;
          end else begin
            ti_next = ti_reg + CW'(1);
            tx_load = 1'b1;
          end
        end
      usbep_pkg::S_WAIT:
        if (sie_ack.valid) begin
          st_next = usbep_pkg::S_IDLE;
          // no ack leaves the bank ready so the host can retry
          if (sie_ack.ok) begin
            txc_next = 1'b1;
            pkr_next[sb_reg] = 1'b0;
            if (pp)
              sb_next = ~sb_reg;
          end
        end
      default: st_next = usbep_pkg::S_IDLE;
    endcase
    if (tx_load) begin
      tx_next.valid = 1'b1;
      tx_next.data  = mem[{sb_reg, ti_next[IW-1:0]}];
      tx_next.empty = len_reg[sb_reg] == '0;
      tx_next.last  = ti_next + CW'(1) >= len_reg[sb_reg];
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_reg <= '0;
      conn_reg <= 1'b0;
      pup_reg  <= 1'b0;
      prdy_reg <= 1'b0;
      prd_reg  <= '0;
      cfg_reg  <= usbep_pkg::CFG_RESET;
      txc_reg  <= 1'b0;
      rxd_reg  <= 1'b0;
      set_reg  <= 1'b0;
      sts_reg  <= 1'b0;
      fst_reg  <= 1'b0;
      pkr_reg  <= '0;
      cb_reg   <= 1'b0;
      sb_reg   <= 1'b0;
      len_reg  <= '{default: '0};
      wp_reg   <= '0;
      rp_reg   <= '0;
      rc_reg   <= '0;
      cnt_reg  <= '0;
      ti_reg   <= '0;
      dir_reg  <= 1'b0;
      hasd_reg <= 1'b0;
      isset_reg <= 1'b0;
      st_reg   <= usbep_pkg::S_IDLE;
      stg_reg  <= usbep_pkg::G_IDLE;
      tx_reg   <= '0;
      hs_reg   <= '0;
    end else if (ce) begin
      sync_reg <= sync_next;
      conn_reg <= conn_next;
      pup_reg  <= pup_next;
      prdy_reg <= prdy_next;
      prd_reg  <= prd_next;
      cfg_reg  <= cfg_next;
      txc_reg  <= txc_next;
      rxd_reg  <= rxd_next;
      set_reg  <= set_next;
      sts_reg  <= sts_next;
      fst_reg  <= fst_next;
      pkr_reg  <= pkr_next;
      cb_reg   <= cb_next;
      sb_reg   <= sb_next;
      len_reg  <= len_next;
      wp_reg   <= wp_next;
      rp_reg   <= rp_next;
      rc_reg   <= rc_next;
      cnt_reg  <= cnt_next;
      ti_reg   <= ti_next;
      dir_reg  <= dir_next;
      hasd_reg <= hasd_next;
      isset_reg <= isset_next;
      st_reg   <= st_next;
      stg_reg  <= stg_next;
      tx_reg   <= tx_next;
      hs_reg   <= hs_next;
    end
  end

  // bus side wins the single write port; cpu writes during a receive
  // would be a software fault anyway
  always_ff @(posedge pclk) begin
    if (ce && mem_we)
      mem[mem_wa] <= mem_wd;
  end
endmodule
`default_nettype wire

// ===== rtl/usbep_pkg.sv
// constants, encodings and carrier types of the usb endpoint block
package usbep_pkg;
  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFF_CFG  = 8'h00;
  localparam logic [7:0] OFF_CSR  = 8'h04;
  localparam logic [7:0] OFF_FDR  = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0C;
  // ==========================================================
  // field positions
  localparam int CFG_PUP  = 0;
  localparam int CFG_PP   = 1;
  localparam int CFG_IEN  = 2;
  localparam int CFG_SZ   = 4;
  localparam int CFG_TYP  = 6;
  localparam int CSR_TXC  = 0;
  localparam int CSR_RXD  = 1;
  localparam int CSR_SET  = 2;
  localparam int CSR_STS  = 3;
  localparam int CSR_PKR  = 4;
  localparam int CSR_FST  = 5;
  localparam int CSR_CNT  = 16;
  localparam int STAT_CON = 0;
  localparam int STAT_STG = 1;
  localparam int STAT_CB  = 4;
  localparam int STAT_SB  = 5;
  // ==========================================================
  // reset values and encodings
  localparam logic [7:0] CFG_RESET = 8'h01;
  localparam logic [1:0] TYP_CTRL  = 2'h0;
  localparam logic [1:0] TYP_ISO   = 2'h1;
  localparam logic [1:0] TYP_BULK  = 2'h2;
  localparam logic [1:0] TYP_INTR  = 2'h3;
  localparam int CTRL_SIZE = 8;
  localparam int BULK_MIN  = 8;
  localparam int INTR_MAX  = 256;
  localparam int SETUP_LEN_LO = 6;
  localparam int SETUP_LEN_HI = 7;
  // ==========================================================
  // enumerations and carriers
  typedef enum logic [1:0] {TK_SETUP, TK_IN, TK_OUT} usbep_kind_t;
  typedef enum logic [1:0] {HS_ACK, HS_NAK, HS_STALL} usbep_code_t;
  typedef enum logic [1:0] {S_IDLE, S_RX, S_TX, S_WAIT} usbep_state_t;
  typedef enum logic [2:0] {G_IDLE, G_SETUP, G_DIN, G_DOUT, G_SIN,
                            G_SOUT} usbep_stage_t;
  typedef struct packed {
    logic        valid;
    usbep_kind_t kind;
  } usbep_tok_t;
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
    logic       empty;
    logic       crc_ok;
  } usbep_rx_t;
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
    logic       empty;
  } usbep_tx_t;
  typedef struct packed {
    logic valid;
    logic ok;
  } usbep_ack_t;
  typedef struct packed {
    logic        valid;
    usbep_code_t code;
  } usbep_hs_t;
endpackage

// ===== tb/usbep_endpoint_assertions.sv
// port checker for the usb endpoint block
`timescale 1ns/1ps
`default_nettype none
module usbep_checker (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic                  ep_irq,
  input wire usbep_pkg::usbep_tok_t sie_tok,
  input wire usbep_pkg::usbep_rx_t  sie_rx,
  input wire usbep_pkg::usbep_ack_t sie_ack,
  input wire logic                  sie_tx_ready,
  input wire usbep_pkg::usbep_tx_t  sie_tx,
  input wire usbep_pkg::usbep_hs_t  sie_hs
);
  logic wr_done;
  assign wr_done = psel & penable & pready & pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ====================
  // sequences
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_acc;
    psel && penable;
  endsequence
  sequence s_last(logic ok);
    sie_rx.valid && sie_rx.last && sie_rx.crc_ok == ok;
  endsequence
  sequence s_in_tok;
    sie_tok.valid && sie_tok.kind == usbep_pkg::TK_IN;
  endsequence
  // ====================
  // properties
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  apb_wait_a: assert property (
    s_setup ##1 s_acc |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  slverr_gate_a: assert property (pslverr |-> pready)
    else $error("pslverr outside pready");
  setup_ack_a: assert property (s_last(1'b1) |=>
    sie_hs.valid && sie_hs.code == usbep_pkg::HS_ACK)
    else $error("good packet not acknowledged");
  crc_bad_a: assert property (s_last(1'b0) |=> !sie_hs.valid)
    else $error("handshake after bad packet");
  in_answer_a: assert property (
    s_in_tok |=> sie_tx.valid ||
    (sie_hs.valid && sie_hs.code != usbep_pkg::HS_ACK))
    else $error("in token left unanswered");
  tx_hold_a: assert property (sie_tx.valid && !sie_tx_ready |=>
    sie_tx.valid && $stable(sie_tx))
    else $error("tx beat changed before taken");
  irq_fall_a: assert property ($fell(ep_irq) |-> $past(wr_done))
    else $error("irq dropped without a write");
  irq_rise_a: assert property (
    $rose(ep_irq) |-> sie_hs.valid ||
    $past(sie_ack.valid && sie_ack.ok) || $past(wr_done))
    else $error("irq rose without a cause");
endmodule
bind usbep_endpoint usbep_checker usbep_checker_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .ep_irq(ep_irq),
  .sie_tok(sie_tok), .sie_rx(sie_rx), .sie_ack(sie_ack),
  .sie_tx_ready(sie_tx_ready), .sie_tx(sie_tx), .sie_hs(sie_hs));
`default_nettype wire

// ===== tb/usbep_endpoint_tb.sv
// self-checking bench for the usb endpoint block
`timescale 1ns/1ps
`default_nettype none
module usbep_endpoint_tb;
  logic                  pclk = 1'b0;
  logic                  presetn = 1'b0;
  logic                  psel = 1'b0;
  logic                  penable = 1'b0;
  logic                  pwrite = 1'b0;
  logic [7:0]            paddr = 8'h00;
  logic [31:0]           pwdata = 32'h0;
  logic                  conn = 1'b1;
  logic                  slow = 1'b0;
  logic                  ce = 1'b0;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  dp_pullup_enable;
  logic                  ep_irq;
  logic                  sie_tx_ready;
  usbep_pkg::usbep_tok_t sie_tok;
  usbep_pkg::usbep_rx_t  sie_rx;
  usbep_pkg::usbep_ack_t sie_ack;
  usbep_pkg::usbep_tx_t  sie_tx;
  usbep_pkg::usbep_hs_t  sie_hs;
  logic [31:0]           seed = 32'h694C875E;
  logic [64:0]           rd_q[$];
  logic [9:0]            tx_q[$];
  logic [1:0]            hs_q[$];
  logic [64:0]           e;
  int                    error_cnt = 0;
  int                    checks_done = 0;
  int                    cyc = 0;
  always #4 pclk = ~pclk;
  usbep_endpoint #(.DEPTH(16)) usbep_endpoint_inst (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .host_connect_sense(conn), .dp_pullup_enable(dp_pullup_enable),
    .ep_irq(ep_irq), .sie_tok(sie_tok), .sie_rx(sie_rx), .sie_ack(sie_ack),
    .sie_tx_ready(sie_tx_ready), .sie_tx(sie_tx), .sie_hs(sie_hs));
  usbep_host usbep_host_inst (
    .pclk(pclk), .slow(slow), .sie_tok(sie_tok), .sie_rx(sie_rx),
    .sie_ack(sie_ack), .sie_tx_ready(sie_tx_ready), .sie_tx(sie_tx),
    .sie_hs(sie_hs));
  // ====================
  // helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int t;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic [31:0] m, input logic err);
    rd_q.push_back({err, m, x});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic fill(input int n);
    for (int i = 0; i < n; i++) usbep_host_inst.pay[i] = 8'(rnd());
  endtask
  task automatic load(input int n);
    logic [7:0] b;
    if (n == 0) tx_q.push_back(10'h003);
    for (int i = 0; i < n; i++) begin
      b = 8'(rnd());
      apb(1'b1, usbep_pkg::OFF_FDR, {24'h0, b});
      tx_q.push_back({b, i == n - 1, 1'b0});
    end
  endtask
  // ====================
  // result watcher and hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      e = rd_q.size() ? rd_q.pop_front() : {1'b1, 64'h0};
      check("prdata", prdata & e[63:32], e[31:0]);
      check("pslverr", pslverr, e[64]);
    end
    if (sie_hs.valid === 1'b1)
      check("hs", sie_hs.code,
            hs_q.size() ? hs_q.pop_front() : 2'h3);
    if (sie_tx.valid === 1'b1 && sie_tx_ready)
      check("tx", {sie_tx.empty ? 8'h00 : sie_tx.data, sie_tx.last,
            sie_tx.empty},
            tx_q.size() ? tx_q.pop_front() : 10'h3FF);
  end
  // ====================
  // main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // enable held low: the pull-up must not follow its config bit yet
    repeat (3) @(posedge pclk);
    check("frozen", dp_pullup_enable, 0);
    ce <= 1'b1;
    rd(usbep_pkg::OFF_CFG, 32'(usbep_pkg::CFG_RESET), 32'hFF,
       1'b0);
    check("pullup", dp_pullup_enable, 1);
    for (int v = 0; v < 2; v++) begin
      conn <= v[0];
      repeat (6) @(posedge pclk);
      rd(usbep_pkg::OFF_STAT, v, 32'h1, 1'b0);
    end
    rd(8'h10, 32'h0, 32'hFFFFFFFF, 1'b1);
    $display("test registers done");
    apb(1'b1, usbep_pkg::OFF_CFG, 32'h05);
    fill(8);
    // host-to-device request with a data stage
    usbep_host_inst.pay[0][7] = 1'b0;
    usbep_host_inst.pay[6] = 8'h01;
    hs_q.push_back(usbep_pkg::HS_ACK);
    usbep_host_inst.send(usbep_pkg::TK_SETUP, 8, 1'b1);
    @(posedge pclk);
    check("irq", ep_irq, 1);
    rd(usbep_pkg::OFF_CSR, 32'h00080004, 32'h01FF000F, 1'b0);
    hs_q.push_back(usbep_pkg::HS_NAK);
    usbep_host_inst.send(usbep_pkg::TK_OUT, 2, 1'b1);
    apb(1'b1, usbep_pkg::OFF_CFG, 32'h01);
    check("irq", ep_irq, 0);
    apb(1'b1, usbep_pkg::OFF_CFG, 32'h05);
    check("irq", ep_irq, 1);
    for (int i = 0; i < 8; i++)
      rd(usbep_pkg::OFF_FDR, usbep_host_inst.pay[i], 32'hFF,
         1'b0);
    apb(1'b1, usbep_pkg::OFF_CSR, 32'h04);
    check("irq", ep_irq, 0);
    fill(2);
    hs_q.push_back(usbep_pkg::HS_ACK);
    usbep_host_inst.send(usbep_pkg::TK_OUT, 2, 1'b1);
    rd(usbep_pkg::OFF_CSR, 32'h00020002, 32'h01FF000F, 1'b0);
    rd(usbep_pkg::OFF_STAT, 32'h6, 32'hE, 1'b0);
    apb(1'b1, usbep_pkg::OFF_CSR, 32'h02);
    $display("test setup done");
    apb(1'b1, usbep_pkg::OFF_CFG, 32'h85);
    fill(9);
    hs_q.push_back(usbep_pkg::HS_ACK);
    usbep_host_inst.send(usbep_pkg::TK_OUT, 9, 1'b1);
    rd(usbep_pkg::OFF_CSR, 32'h00080002, 32'h01FF000F, 1'b0);
    apb(1'b1, usbep_pkg::OFF_CSR, 32'h02);
    apb(1'b1, usbep_pkg::OFF_CFG, 32'hC5);
    hs_q.push_back(usbep_pkg::HS_ACK);
    usbep_host_inst.send(usbep_pkg::TK_OUT, 3, 1'b1);
    rd(usbep_pkg::OFF_CSR, 32'h00030002, 32'h01FF000F, 1'b0);
    apb(1'b1, usbep_pkg::OFF_CSR, 32'h02);
    usbep_host_inst.send(usbep_pkg::TK_OUT, 3, 1'b0);
    hs_q.push_back(usbep_pkg::HS_NAK);
    usbep_host_inst.fetch(1'b1);
    slow <= 1'b1;
    for (int n = 3; n >= 0; n -= 3) begin
      rd(usbep_pkg::OFF_CSR, 32'h0, 32'h10, 1'b0);
      load(n);
      apb(1'b1, usbep_pkg::OFF_CSR, 32'h10);
      rd(usbep_pkg::OFF_CSR, 32'h10, 32'h10, 1'b0);
      usbep_host_inst.fetch(1'b1);
      rd(usbep_pkg::OFF_CSR, 32'h01, 32'h11, 1'b0);
      check("irq", ep_irq, 1);
      apb(1'b1, usbep_pkg::OFF_CSR, 32'h01);
      check("irq", ep_irq, 0);
    end
    $display("test single bank in done");
    apb(1'b1, usbep_pkg::OFF_CSR, 32'h20);
    hs_q.push_back(usbep_pkg::HS_STALL);
    usbep_host_inst.fetch(1'b1);
    hs_q.push_back(usbep_pkg::HS_STALL);
    usbep_host_inst.send(usbep_pkg::TK_OUT, 1, 1'b1);
    rd(usbep_pkg::OFF_CSR, 32'h28, 32'h28, 1'b0);
    apb(1'b1, usbep_pkg::OFF_CSR, 32'h08);
    check("irq", ep_irq, 0);
    $display("test stall done");
    apb(1'b1, usbep_pkg::OFF_CFG, 32'h47);
    slow <= 1'(rnd());
    load(2);
    apb(1'b1, usbep_pkg::OFF_CSR, 32'h10);
    load(1);
    rd(usbep_pkg::OFF_STAT, 32'h10, 32'h10, 1'b0);
    usbep_host_inst.fetch(1'b1);
    rd(usbep_pkg::OFF_CSR, 32'h01, 32'h01, 1'b0);
    apb(1'b1, usbep_pkg::OFF_CSR, 32'h01);
    apb(1'b1, usbep_pkg::OFF_CSR, 32'h10);
    rd(usbep_pkg::OFF_STAT, 32'h0, 32'h10, 1'b0);
    usbep_host_inst.fetch(1'b1);
    $display("test ping-pong done");
    repeat (4) @(posedge pclk);
    check("left", rd_q.size() + tx_q.size() + hs_q.size(), 0);
    close_out();
  end
endmodule
`default_nettype wire

// ===== tb/usbep_host.sv
// usb host model: tokens, out data, in data sink and acks
`timescale 1ns/1ps
`default_nettype none
module usbep_host (
  input  wire logic                  pclk,
  input  wire logic                  slow,
  output var  usbep_pkg::usbep_tok_t sie_tok,
  output var  usbep_pkg::usbep_rx_t  sie_rx,
  output var  usbep_pkg::usbep_ack_t sie_ack,
  output var  logic                  sie_tx_ready,
  input  wire usbep_pkg::usbep_tx_t  sie_tx,
  input  wire usbep_pkg::usbep_hs_t  sie_hs
);
  logic [7:0] pay [0:15];
  initial begin
    sie_tok = '0;
    sie_rx = '0;
    sie_ack = '0;
    sie_tx_ready = 1'b0;
  end
  // slow sink takes every other beat
  always @(posedge pclk) sie_tx_ready <= !slow || !sie_tx_ready;
  // ====================
  // setup is never refused; out data only follows an unrefused token
  task automatic send(input usbep_pkg::usbep_kind_t k, input int n,
                      input logic ok);
    sie_tok <= '{1'b1, k};
    @(posedge pclk);
    sie_tok <= '0;
    if (k == usbep_pkg::TK_OUT) begin
      @(posedge pclk);
      if (sie_hs.valid) return;
    end
    for (int i = 0; i < (n > 0 ? n : 1); i++) begin
      sie_rx <= '{1'b1, pay[i], i >= n - 1, n == 0, ok};
      @(posedge pclk);
    end
    // released data line must not keep its last value
    sie_rx <= '{1'b0, ~sie_rx.data, 1'b0, 1'b0, 1'b0};
  endtask
  task automatic fetch(input logic ok);
    int t;
    sie_tok <= '{1'b1, usbep_pkg::TK_IN};
    @(posedge pclk);
    sie_tok <= '0;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
      if (sie_hs.valid) return;
    end while (!(sie_tx.valid && sie_tx_ready && sie_tx.last) && t < 99);
    @(posedge pclk);
    sie_ack <= '{1'b1, ok};
    @(posedge pclk);
    sie_ack <= '0;
  endtask
endmodule
`default_nettype wire
